/* rtl/plcs_link_ctrl_status.v */
// Purpose: Link control and link status registers of one switch port
// Assumes: Status inputs come from the port's training and link logic
// Notes:   Port role and slot clock default are caught after reset
//
// How it works
// [RQ1] Policy field picks none, L0s, L1, both
// [RQ2] Receiver may always enter L0s
// [RQ3] Completion boundary bit reads zero
// [RQ4] Link disable downstream only, zero upstream
// [RQ5] Retrain write pulses downstream, reads zero
// [RQ6] Common clock bit records reference clocking
// [RQ7] Extended sync sends 4096 FTS, 1024 TS1
// [RQ8] Clock PM off holds CLKREQ# low
// [RQ9] Bandwidth interrupt enables writable downstream only
// [RQ10] Speed field reports negotiated speed code
// [RQ11] Width field reports negotiated lane count
// [RQ12] Training error set on fail, cleared in L0
// [RQ13] Training flag follows training progress
// [RQ14] Slot clock flag from loadable default
// [RQ15] Data link active mirrors DL_Active
// [RQ16] Bandwidth status set by hardware, write-one-clear
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "plcs_consts.vh"

module plcs_link_ctrl_status (
   // Clock and reset
   input  wire        core_clk,
   input  wire        arst_n,
   // Register port
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_wr,
   input  wire        reg_rd,
   output reg  [31:0] reg_rdata,
   // Straps and loadable defaults
   input  wire        port_is_up,
   input  wire        slot_clk_dflt,
   input  wire        slot_clk_load,
   input  wire        slot_clk_val,
   // Training and link state
   input  wire [3:0]  neg_speed,
   input  wire [5:0]  neg_width,
   input  wire        train_busy,
   input  wire        train_fail,
   input  wire        link_in_l0,
   input  wire        dl_active,
   input  wire        bw_mgmt_evt,
   input  wire        auto_bw_evt,
   // Power state exits and ordered sets
   input  wire        exit_l0s,
   input  wire        exit_l1,
   input  wire        os_sent,
   input  wire        clk_idle,
   // Control to link logic
   output wire        active_state_power_policy_l0s_en,
   output wire        active_state_power_policy_l1_en,
   output wire        rx_l0s_allowed,
   output wire        link_disable,
   output reg         retrain_pulse,
   output wire        common_clk,
   output wire        hw_width_off,
   output wire        send_fts,
   output wire        send_ts1,
   // Clock request pin
   input  wire        clkreq_n_i,
   output wire        clkreq_n_o,
   output wire        clkreq_n_oe,
   // Interrupt
   output wire        irq
);

   // Byte address match
   function addr_hit;
      input [7:0] addr;
      input [7:0] offs;
      begin
         addr_hit = (addr == offs);
      end
   endfunction

   // Policy decode
   function active_state_power_policy_allows;
      input [1:0] pol;
      input [1:0] want;
      begin
         active_state_power_policy_allows = (pol == want) || (pol == `PLCS_ACTIVE_STATE_POWER_POLICY_BOTH);
      end
   endfunction

   // Control register state
   reg [1:0]  active_state_power_policy_q;
   reg        ldis_q;
   reg        cclk_q;
   reg        extsync_q;
   reg        clkpm_q;
   reg        hawd_q;
   reg        bwmie_q;
   reg        abwie_q;

   // Status register state
   reg [3:0]  speed_q;
   reg [5:0]  width_q;
   reg        terr_q;
   reg        train_q;
   reg        sclk_q;
   reg        dlact_q;
   reg        bwms_q;
   reg        abws_q;

   // Straps
   reg        strap_done_q;
   reg        port_up_q;

   // Interrupt state
   reg [`PLCS_IRQ_W-1:0] irq_stat_q;
   reg [`PLCS_IRQ_W-1:0] irq_en_q;
   reg [`PLCS_IRQ_W-1:0] irq_evt;
   reg                   terr_d;

   // Clock request release
   reg        clkreq_rel_q;

   wire       wr_cs;
   wire       wr_clr;
   wire       wr_en;
   wire       down;
   wire [15:0] ctrl_word;
   wire [15:0] stat_word;
   wire [`PLCS_OS_W-1:0] os_left;

   assign wr_cs  = reg_wr && addr_hit(reg_addr, `PLCS_LINK_CS_ADDR);
   assign wr_clr = reg_wr && addr_hit(reg_addr, `PLCS_IRQ_CLR_ADDR);
   assign wr_en  = reg_wr && addr_hit(reg_addr, `PLCS_IRQ_EN_ADDR);
   assign down   = !port_up_q;

   // Straps caught at the first edge after reset release
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         strap_done_q <= 1'b0;
         port_up_q    <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         port_up_q    <= port_is_up;
      end
   end

   // Writable control fields
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         active_state_power_policy_q    <= `PLCS_ACTIVE_STATE_POWER_POLICY_OFF; // [RQ1]
         ldis_q    <= 1'b0;
         cclk_q    <= 1'b0;
         extsync_q <= 1'b0;
         clkpm_q   <= 1'b0;
         hawd_q    <= 1'b0;
         bwmie_q   <= 1'b0;
         abwie_q   <= 1'b0;
      end else if (wr_cs) begin
         active_state_power_policy_q    <= reg_wdata[`PLCS_ACTIVE_STATE_POWER_POLICY_HI:`PLCS_ACTIVE_STATE_POWER_POLICY_LO]; // [RQ1]
         ldis_q    <= down && reg_wdata[`PLCS_LDIS_BIT]; // [RQ4]
         cclk_q    <= reg_wdata[`PLCS_CCLK_BIT]; // [RQ6]
         extsync_q <= reg_wdata[`PLCS_EXTSYNC_BIT]; // [RQ7]
         clkpm_q   <= port_up_q && reg_wdata[`PLCS_CLKPM_BIT]; // [RQ8]
         hawd_q    <= reg_wdata[`PLCS_HAWD_BIT];
         if (down) begin
            bwmie_q <= reg_wdata[`PLCS_BWMIE_BIT]; // [RQ9]
            abwie_q <= reg_wdata[`PLCS_ABWIE_BIT]; // [RQ9]
         end
      end
   end

   // Retrain request, one cycle, downstream only
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         retrain_pulse <= 1'b0;
      end else begin
         retrain_pulse <= wr_cs && down && reg_wdata[`PLCS_RETRAIN_BIT]; // [RQ5]
      end
   end

   // Negotiated speed and width taken every cycle while not training and in L0
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         speed_q <= `PLCS_SPEED_5G0; // [RQ10]
         width_q <= `PLCS_WIDTH_RST; // [RQ11]
      end else if (!train_busy && link_in_l0) begin
         speed_q <= neg_speed; // [RQ10]
         width_q <= neg_width; // [RQ11]
      end
   end

   // Training error: failure beats clearing in L0
   always @* begin
      terr_d = terr_q;
      if (!train_busy && link_in_l0) begin
         terr_d = 1'b0; // [RQ12]
      end
      if (train_fail) begin
         terr_d = 1'b1; // [RQ12]
      end
   end

   // Training, slot clock and data link flags
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         terr_q  <= 1'b0;
         train_q <= `PLCS_TRAIN_RST; // [RQ13]
         sclk_q  <= 1'b1;
         dlact_q <= 1'b0;
      end else begin
         terr_q  <= terr_d;
         train_q <= train_busy; // [RQ13]
         dlact_q <= dl_active; // [RQ15]
         if (!strap_done_q) begin
            sclk_q <= slot_clk_dflt; // [RQ14]
         end else if (slot_clk_load) begin
            sclk_q <= slot_clk_val; // [RQ14]
         end
      end
   end

   // Bandwidth status bits, set wins over write-one-clear
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         bwms_q <= 1'b0;
         abws_q <= 1'b0;
      end else begin
         if (bw_mgmt_evt) begin
            bwms_q <= 1'b1; // [RQ16]
         end else if (wr_cs && reg_wdata[`PLCS_BWMS_BIT]) begin
            bwms_q <= 1'b0; // [RQ16]
         end
         if (auto_bw_evt) begin
            abws_q <= 1'b1; // [RQ16]
         end else if (wr_cs && reg_wdata[`PLCS_ABWS_BIT]) begin
            abws_q <= 1'b0; // [RQ16]
         end
      end
   end

   // Interrupt events
   always @* begin
      irq_evt                 = {`PLCS_IRQ_W{1'b0}};
      irq_evt[`PLCS_IRQ_BWM]  = bw_mgmt_evt && bwmie_q;
      irq_evt[`PLCS_IRQ_ABW]  = auto_bw_evt && abwie_q;
      irq_evt[`PLCS_IRQ_TERR] = train_fail && !terr_q;
      irq_evt[`PLCS_IRQ_DLUP] = dl_active && !dlact_q;
      irq_evt[`PLCS_IRQ_DLDN] = !dl_active && dlact_q;
   end

   // Sticky interrupt status and enable
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_q <= {`PLCS_IRQ_W{1'b0}};
         irq_en_q   <= {`PLCS_IRQ_W{1'b0}};
      end else begin
         if (wr_clr) begin
            irq_stat_q <= (irq_stat_q & ~reg_wdata[`PLCS_IRQ_W-1:0]) | irq_evt;
         end else begin
            irq_stat_q <= irq_stat_q | irq_evt;
         end
         if (wr_en) begin
            irq_en_q <= reg_wdata[`PLCS_IRQ_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_q & irq_en_q);

   // Clock request release only when permitted and idle
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         clkreq_rel_q <= 1'b0;
      end else begin
         clkreq_rel_q <= clkpm_q && clk_idle; // [RQ8]
      end
   end

   assign clkreq_n_o  = 1'b0;
   assign clkreq_n_oe = !clkreq_rel_q; // [RQ8]

   // Read views
   assign ctrl_word = {4'h0,
                       abwie_q,
                       bwmie_q,
                       hawd_q,
                       clkpm_q,
                       extsync_q,
                       cclk_q,
                       1'b0,
                       ldis_q,
                       1'b0,
                       1'b0,
                       active_state_power_policy_q}; // [RQ3] [RQ5]
   assign stat_word = {abws_q,
                       bwms_q,
                       dlact_q,
                       sclk_q,
                       train_q,
                       terr_q,
                       width_q,
                       speed_q};

   // Read data one cycle after the strobe
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         if (addr_hit(reg_addr, `PLCS_LINK_CS_ADDR)) begin
            reg_rdata <= {stat_word, ctrl_word};
         end else if (addr_hit(reg_addr, `PLCS_IRQ_STAT_ADDR)) begin
            reg_rdata <= {23'h000000, clkreq_n_i, 3'h0, irq_stat_q};
         end else if (addr_hit(reg_addr, `PLCS_IRQ_EN_ADDR)) begin
            reg_rdata <= {27'h0000000, irq_en_q};
         end else begin
            reg_rdata <= 32'h0000_0000;
         end
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // Control outputs
   assign active_state_power_policy_l0s_en    = active_state_power_policy_allows(active_state_power_policy_q, `PLCS_ACTIVE_STATE_POWER_POLICY_L0S); // [RQ1]
   assign active_state_power_policy_l1_en     = active_state_power_policy_allows(active_state_power_policy_q, `PLCS_ACTIVE_STATE_POWER_POLICY_L1); // [RQ1]
   assign rx_l0s_allowed = 1'b1; // [RQ2]
   assign link_disable   = ldis_q && down; // [RQ4]
   assign common_clk     = cclk_q; // [RQ6]
   assign hw_width_off   = hawd_q;

   // Ordered set bursts on exit from low power
   plcs_os_burst u_os_burst (
      .core_clk (core_clk),
      .arst_n   (arst_n),
      .ext_sync (extsync_q),
      .exit_l0s (exit_l0s),
      .exit_l1  (exit_l1),
      .os_sent  (os_sent),
      .send_fts (send_fts),
      .send_ts1 (send_ts1),
      .os_left  (os_left)
   );

endmodule

/* rtl/plcs_consts.vh */
// Purpose: Constants of the port link control and status registers
// Assumes: Byte addresses on an 8-bit register port
// Notes:   Definitions only
`ifndef PLCS_CONSTS_VH
`define PLCS_CONSTS_VH

// Register byte addresses
`define PLCS_LINK_CS_ADDR    8'hd0
`define PLCS_IRQ_STAT_ADDR   8'he0
`define PLCS_IRQ_CLR_ADDR    8'he4
`define PLCS_IRQ_EN_ADDR     8'he8

// Link control fields
`define PLCS_ACTIVE_STATE_POWER_POLICY_LO         0
`define PLCS_ACTIVE_STATE_POWER_POLICY_HI         1
`define PLCS_RCB_BIT         3
`define PLCS_LDIS_BIT        4
`define PLCS_RETRAIN_BIT     5
`define PLCS_CCLK_BIT        6
`define PLCS_EXTSYNC_BIT     7
`define PLCS_CLKPM_BIT       8
`define PLCS_HAWD_BIT        9
`define PLCS_BWMIE_BIT       10
`define PLCS_ABWIE_BIT       11

// Link status fields, word bit positions
`define PLCS_SPEED_LO        16
`define PLCS_SPEED_HI        19
`define PLCS_WIDTH_LO        20
`define PLCS_WIDTH_HI        25
`define PLCS_TERR_BIT        26
`define PLCS_TRAIN_BIT       27
`define PLCS_SCLK_BIT        28
`define PLCS_DLACT_BIT       29
`define PLCS_BWMS_BIT        30
`define PLCS_ABWS_BIT        31

// Policy encodings
`define PLCS_ACTIVE_STATE_POWER_POLICY_OFF        2'h0
`define PLCS_ACTIVE_STATE_POWER_POLICY_L0S        2'h1
`define PLCS_ACTIVE_STATE_POWER_POLICY_L1         2'h2
`define PLCS_ACTIVE_STATE_POWER_POLICY_BOTH       2'h3

// Speed codes and reset values
`define PLCS_SPEED_2G5       4'h1
`define PLCS_SPEED_5G0       4'h2
`define PLCS_WIDTH_RST       6'h01
`define PLCS_TRAIN_RST       1'h1

// Interrupt status bits
`define PLCS_IRQ_W           5
`define PLCS_IRQ_BWM         0
`define PLCS_IRQ_ABW         1
`define PLCS_IRQ_TERR        2
`define PLCS_IRQ_DLUP        3
`define PLCS_IRQ_DLDN        4

// Ordered set counts
`define PLCS_OS_W            13
`define PLCS_FTS_EXT         13'h1000
`define PLCS_TS1_EXT         13'h0400
`define PLCS_FTS_NORM        13'h0020
`define PLCS_TS1_NORM        13'h0010

`endif

/* rtl/plcs_os_burst.v */
// Purpose: Counts ordered sets sent on an exit from L0s or L1
// Assumes: os_sent pulses once per ordered set transmitted
// Notes:   A new exit is ignored while a burst runs
`timescale 1ns/1ps
`include "plcs_consts.vh"

module plcs_os_burst (
   // Clock and reset
   input  wire                   core_clk,
   input  wire                   arst_n,
   // Control
   input  wire                   ext_sync,
   input  wire                   exit_l0s,
   input  wire                   exit_l1,
   input  wire                   os_sent,
   // Burst status
   output reg                    send_fts,
   output reg                    send_ts1,
   output wire [`PLCS_OS_W-1:0]  os_left
);

   reg [`PLCS_OS_W-1:0] left_q;
   reg [`PLCS_OS_W-1:0] left_d;
   reg                  fts_d;
   reg                  ts1_d;

   assign os_left = left_q;

   // Burst length chosen by sync mode
   always @* begin
      left_d = left_q;
      fts_d  = send_fts;
      ts1_d  = send_ts1;
      if (send_fts || send_ts1) begin
         if (os_sent) begin
            left_d = left_q - 13'h0001;
            if (left_q == 13'h0001) begin
               fts_d = 1'b0;
               ts1_d = 1'b0;
            end
         end
      end else if (exit_l0s) begin
         left_d = ext_sync ? `PLCS_FTS_EXT : `PLCS_FTS_NORM; // [RQ7]
         fts_d  = 1'b1;
      end else if (exit_l1) begin
         left_d = ext_sync ? `PLCS_TS1_EXT : `PLCS_TS1_NORM; // [RQ7]
         ts1_d  = 1'b1;
      end
   end

   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         left_q   <= 13'h0000;
         send_fts <= 1'b0;
         send_ts1 <= 1'b0;
      end else begin
         left_q   <= left_d;
         send_fts <= fts_d;
         send_ts1 <= ts1_d;
      end
   end

endmodule

/* sim/plcs_lcs_assertions.sv */
// Purpose: Port checks of the link control and status block
// Assumes: Straps change only under reset
// Notes:   Bound to the block from the bench top
`timescale 1ns/1ps
module plcs_lcs_checker (
   // Clock and reset
   input wire        core_clk,
   input wire        arst_n,
   // Register port
   input wire [7:0]  reg_addr,
   input wire [31:0] reg_wdata,
   input wire        reg_wr,
   input wire        reg_rd,
   input wire [31:0] reg_rdata,
   // Link side
   input wire        port_is_up,
   input wire        dl_active,
   input wire        exit_l0s,
   input wire        exit_l1,
   input wire        os_sent,
   input wire        active_state_power_policy_l0s_en,
   input wire        active_state_power_policy_l1_en,
   input wire        rx_l0s_allowed,
   input wire        link_disable,
   input wire        retrain_pulse,
   input wire        send_fts,
   input wire        send_ts1,
   input wire        clkreq_n_o,
   input wire        clkreq_n_oe
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!arst_n);
   wire       wr_d0 = reg_wr && reg_addr == 8'hd0;
   wire       rd_d0 = reg_rd && reg_addr == 8'hd0;
   wire       burst = send_fts || send_ts1;
   wire       ro_ok = port_is_up ? reg_rdata[11:10] == 2'h0 && !reg_rdata[4] : !reg_rdata[8];
   reg [12:0] os_cnt_q;
   // Sets taken during the running burst
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         os_cnt_q <= 13'h0;
      else
         os_cnt_q <= burst ? os_cnt_q + {12'h0, os_sent} : 13'h0;
   end
   policy_write_a: assert property (wr_d0 |=> {active_state_power_policy_l1_en, active_state_power_policy_l0s_en} == $past(reg_wdata[1:0]))
      else $error("policy enables do not follow the write");
   rx_l0s_a: assert property (rx_l0s_allowed)
      else $error("receiver L0s entry blocked");
   ctrl_read_a: assert property (rd_d0 |=> !reg_rdata[3] && !reg_rdata[5] && ro_ok)
      else $error("fixed control bit read back nonzero");
   link_disable_a: assert property (wr_d0 |=> link_disable == ($past(reg_wdata[4]) && !port_is_up))
      else $error("link disable wrong");
   retrain_start_a: assert property (wr_d0 |=> retrain_pulse == ($past(reg_wdata[5]) && !port_is_up))
      else $error("retrain pulse wrong");
   clkreq_low_a: assert property (wr_d0 && !reg_wdata[8] ##1 !wr_d0 |=> clkreq_n_oe && !clkreq_n_o)
      else $error("clock request not held low");
   dl_mirror_a: assert property (rd_d0 && $stable(dl_active) |=> reg_rdata[29] == $past(dl_active))
      else $error("data link active flag wrong");
   burst_start_a: assert property ((exit_l0s || exit_l1) && !burst |=> send_fts == $past(exit_l0s))
      else $error("burst kind wrong");
   fts_count_a: assert property ($fell(send_fts) |-> os_cnt_q == 13'h0020 || os_cnt_q == 13'h1000)
      else $error("wrong number of fast sets");
   ts1_count_a: assert property ($fell(send_ts1) |-> os_cnt_q == 13'h0010 || os_cnt_q == 13'h0400)
      else $error("wrong number of training sets");
   cover property (wr_d0 && reg_wdata[5] && !port_is_up);
   cover property ($fell(send_fts));
   cover property ($fell(send_ts1));
endmodule

/* sim/plcs_link_partner.sv */
// Purpose: Far link end taking ordered set bursts
// Assumes: One os_sent per set taken
// Notes:   Slow mode takes a set every third cycle
`timescale 1ns/1ps
module plcs_link_partner (
   // Clock and reset
   input  wire core_clk,
   input  wire arst_n,
   // Burst status
   input  wire send_fts,
   input  wire send_ts1,
   input  wire slow,
   // Set taken
   output wire os_sent
);
   reg [1:0] tick_q;
   always @(posedge core_clk or negedge arst_n) begin
      if (!arst_n)
         tick_q <= 2'h0;
      else
         tick_q <= (tick_q == 2'h2) ? 2'h0 : tick_q + 2'h1;
   end
   // Sets only while a burst runs
   assign os_sent = (send_fts || send_ts1) && (!slow || tick_q == 2'h0);
endmodule

/* sim/pcie_port_link_ctrl_status_test.sv */
// Purpose: Bench of the link control and status block
// Assumes: Straps change only under reset
// Notes:   Runs as downstream port, then upstream
`timescale 1ns/1ps
bind plcs_link_ctrl_status plcs_lcs_checker u_chk (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .port_is_up, .dl_active, .exit_l0s, .exit_l1, .os_sent, .active_state_power_policy_l0s_en, .active_state_power_policy_l1_en, .rx_l0s_allowed,
   .link_disable, .retrain_pulse, .send_fts, .send_ts1, .clkreq_n_o, .clkreq_n_oe);
module pcie_port_link_ctrl_status_test;
   reg         core_clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, slow = 0;
   reg [7:0]   reg_addr = 8'h0;
   reg [31:0]  reg_wdata = 32'h0, rd_q, d;
   reg         port_is_up = 0, slot_clk_dflt = 1, slot_clk_load = 0, slot_clk_val = 0;
   reg [3:0]   neg_speed = 4'h2;
   reg [5:0]   neg_width = 6'h01;
   reg         train_busy = 1, train_fail = 0, link_in_l0 = 0, dl_active = 0;
   reg         bw_mgmt_evt = 0, auto_bw_evt = 0, exit_l0s = 0, exit_l1 = 0, clk_idle = 0, clkreq_n_i = 1;
   wire [31:0] reg_rdata;
   wire        active_state_power_policy_l0s_en, active_state_power_policy_l1_en, rx_l0s_allowed, link_disable, retrain_pulse, common_clk, hw_width_off;
   wire        send_fts, send_ts1, os_sent, clkreq_n_o, clkreq_n_oe, irq;
   integer     errors = 0, n_compared = 0, i, k, n;
   plcs_link_ctrl_status DUT (.core_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_is_up,
      .slot_clk_dflt, .slot_clk_load, .slot_clk_val, .neg_speed, .neg_width, .train_busy, .train_fail, .link_in_l0,
      .dl_active, .bw_mgmt_evt, .auto_bw_evt, .exit_l0s, .exit_l1, .os_sent, .clk_idle, .active_state_power_policy_l0s_en, .active_state_power_policy_l1_en,
      .rx_l0s_allowed, .link_disable, .retrain_pulse, .common_clk, .hw_width_off, .send_fts, .send_ts1, .clkreq_n_i,
      .clkreq_n_o, .clkreq_n_oe, .irq);
   plcs_link_partner u_far (.core_clk, .arst_n, .send_fts, .send_ts1, .slow, .os_sent);
   always #12.5 core_clk = ~core_clk;
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared = n_compared + 1;
      if (s !== e) begin
         errors = errors + 1;
         $display("unexpected %s expected %h seen %h", nm, e, s);
      end
   endtask
   task end_of_test;
      if (errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   function [15:0] st(input [3:0] sp, input [5:0] w, input te, tr, sc, dl);
      st = {2'h0, dl, sc, tr, te, w, sp};
   endfunction
   function [31:0] n_sets(input ext, input l1);
      n_sets = ext ? (l1 ? 32'h400 : 32'h1000) : (l1 ? 32'h10 : 32'h20);
   endfunction
   task wr(input [7:0] a, input [31:0] v);
      reg_wr <= 1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk) reg_wr <= 0;
      @(posedge core_clk);
   endtask
   task rd(input [7:0] a);
      reg_rd <= 1;
      reg_addr <= a;
      @(posedge core_clk) reg_rd <= 0;
      #1 rd_q = reg_rdata;
      @(posedge core_clk);
   endtask
   task start(input up);
      arst_n <= 0;
      port_is_up <= up;
      slot_clk_dflt <= !up;
      train_busy <= 1;
      link_in_l0 <= 0;
      repeat (10) @(posedge core_clk);
      arst_n <= 1;
      repeat (2) @(posedge core_clk);
   endtask
   task ctrl_rand(input [15:0] m);
      for (i = 0; i < 16; i++) begin
         d = $urandom;
         clk_idle <= d[20];
         wr(8'hd0, d & 32'h3fff_ffff);
         rd(8'hd0);
         chk("control", rd_q[15:0], d[15:0] & m);
         chk("policy enables", {active_state_power_policy_l1_en, active_state_power_policy_l0s_en}, d[1:0]);
         chk("link disable", link_disable, d[4] & m[4]);
         chk("clock and width controls", {hw_width_off, common_clk}, {d[9], d[6]});
         chk("clock request enable", clkreq_n_oe, !(d[8] && m[8] && d[20]));
      end
   endtask
   initial begin
      d = $urandom(57093);
      start(0);
      rd(8'hd0);
      chk("status", rd_q[31:16], st(4'h2, 6'h01, 0, 1, 1, 0));
      chk("control", rd_q[15:0], 16'h0);
      ctrl_rand(16'h0ed3);
      train_fail <= 1;
      @(posedge core_clk) train_fail <= 0;
      rd(8'hd0);
      chk("training error", rd_q[26], 1'h1);
      d = $urandom_range(1, 32);
      neg_speed <= 4'h1;
      neg_width <= d[5:0];
      train_busy <= 0;
      link_in_l0 <= 1;
      dl_active <= 1;
      repeat (3) @(posedge core_clk);
      rd(8'hd0);
      chk("status", rd_q[31:16], st(4'h1, d[5:0], 0, 0, 1, 1));
      slot_clk_load <= 1;
      @(posedge core_clk) slot_clk_load <= 0;
      rd(8'hd0);
      chk("slot clock", rd_q[28], 1'h0);
      wr(8'he4, 32'h1f);
      wr(8'he8, 32'h03);
      wr(8'hd0, 32'h0c00);
      #1 chk("irq", irq, 1'h0);
      @(posedge core_clk);
      bw_mgmt_evt <= 1;
      auto_bw_evt <= 1;
      @(posedge core_clk) bw_mgmt_evt <= 0;
      auto_bw_evt <= 0;
      #1 chk("irq", irq, 1'h1);
      @(posedge core_clk);
      rd(8'he0);
      chk("irq status", rd_q[1:0], 2'h3);
      chk("clock request pin", rd_q[8], clkreq_n_i);
      rd(8'hd0);
      chk("bandwidth status", rd_q[31:30], 2'h3);
      wr(8'he8, 32'h0);
      #1 chk("masked irq", irq, 1'h0);
      @(posedge core_clk);
      wr(8'hd0, 32'hc000_0c00);
      rd(8'hd0);
      chk("bandwidth status", rd_q[31:30], 2'h0);
      rd(8'h10);
      chk("unmapped", rd_q, 32'h0);
      for (k = 0; k < 4; k++) begin
         wr(8'hd0, {24'h0, k[1], 7'h0});
         slow <= !k[1];
         exit_l0s <= !k[0];
         exit_l1 <= k[0];
         @(posedge core_clk) exit_l0s <= 0;
         exit_l1 <= 0;
         n = 0;
         for (i = 0; i < 6000; i++) begin
            @(posedge core_clk);
            exit_l0s <= i == 4 && k[0];
            exit_l1 <= i == 4 && !k[0];
            if (i == 0)
               chk("burst kind", send_ts1, k[0]);
            if (!send_fts && !send_ts1)
               break;
            n = n + os_sent;
         end
         if (i == 6000) begin
            errors = errors + 1;
            end_of_test;
         end
         chk("burst sets", n, n_sets(k[1], k[0]));
      end
      start(1);
      rd(8'hd0);
      chk("slot clock", rd_q[28], 1'h0);
      ctrl_rand(16'h03c3);
      end_of_test;
   end
endmodule
